//--- shared/opfsr_pkg.sv
package opfsr_pkg;

    // Register offsets on the management bus
    localparam logic [7:0]  OFS_POLARITY    = 8'h13;
    localparam logic [7:0]  OFS_DIV_TRIM    = 8'h14;
    localparam logic [7:0]  OFS_AMP_TRIM    = 8'h15;
    localparam logic [7:0]  OFS_GAIN_RANGE  = 8'h16;
    localparam logic [7:0]  OFS_SENSE_MODE  = 8'h17;
    localparam logic [7:0]  OFS_FALSE_UV    = 8'h18;
    localparam logic [7:0]  OFS_LOAD_V      = 8'h19;
    localparam logic [7:0]  OFS_MASK_A      = 8'h1A;
    localparam logic [7:0]  OFS_MASK_B      = 8'h1B;

    // Bank geometry and shadow location of the first register
    localparam int          NUM_REGS        = 9;
    localparam logic [3:0]  LAST_IDX        = 4'h8;
    localparam logic [15:0] SHADOW_BASE     = 16'h8113;

    // Field positions in the polarity register
    localparam int          POL_PWR_EN_BIT  = 7;
    localparam int          POL_FAULT_BIT   = 6;
    localparam int          POL_DC_BIT      = 5;
    localparam int          POL_AC_BIT      = 4;
    localparam int          POL_ORING_BIT   = 3;
    localparam int          SHARE_CLAMP_BIT = 2;
    localparam int          SW_FAULT_BIT    = 1;
    localparam int          LATCH_CLR_BIT   = 0;

    // Share clamp bit reads back as zero; mask B bit 0 is unused, kept in readback but dropped from gating
    localparam logic [7:0]  POL_READ_MASK   = 8'hFB;
    localparam logic [7:0]  MASK_B_USED     = 8'hFE;

    // Sources given as "good" levels, inverted to make fault flags
    localparam logic [7:0]  SRC_A_INVERT    = 8'h13;
    localparam logic [7:0]  SRC_B_INVERT    = 8'h80;

    // Bank value from reset until each register's own shadow byte is loaded; read data for unmapped offsets
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [7:0]  RDATA_RESET     = 8'h00;

    typedef enum logic [1:0] {
        OPFSR_LD_REQ  = 2'b00,
        OPFSR_LD_WAIT = 2'b01,
        OPFSR_LD_DONE = 2'b10
    } opfsr_ld_state_t;

endpackage : opfsr_pkg

//--- core/opfsr_shadow_loader.sv
////////////////////////////////////////////////////////////////////////////////
// Walks the shadow store once after reset and hands each byte to the bank
module opfsr_shadow_loader (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    output logic             shadow_rd_req,
    output logic [15:0]      shadow_addr,
    input  wire logic        shadow_rd_ack,
    input  wire logic [7:0]  shadow_rdata,
    output logic             load_we,
    output logic [3:0]       load_idx,
    output logic [7:0]       load_data,
    output logic             load_done
);

    typedef struct packed {
        opfsr_pkg::opfsr_ld_state_t st;
        logic [3:0]                 idx;
        logic                       we;
        logic [7:0]                 data;
    } opfsr_ldr_t;

    opfsr_ldr_t s_q;
    opfsr_ldr_t s_d;

    // One request per register, in offset order; the ack carries the byte
    always_comb begin
        s_d    = s_q;
        s_d.we = 1'b0;
        case (s_q.st)
            opfsr_pkg::OPFSR_LD_REQ: begin
                s_d.st = opfsr_pkg::OPFSR_LD_WAIT;
            end
            opfsr_pkg::OPFSR_LD_WAIT: begin
                if (shadow_rd_ack) begin
                    s_d.we   = 1'b1;
                    s_d.data = shadow_rdata;
                    if (s_q.idx == opfsr_pkg::LAST_IDX) begin
                        s_d.st = opfsr_pkg::OPFSR_LD_DONE;
                    end else begin
                        s_d.idx = s_q.idx + 4'h1;
                        s_d.st  = opfsr_pkg::OPFSR_LD_REQ;
                    end
                end
            end
            opfsr_pkg::OPFSR_LD_DONE: begin
                s_d.st = opfsr_pkg::OPFSR_LD_DONE;
            end
            default: begin
                s_d.st = opfsr_pkg::OPFSR_LD_REQ;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{st: opfsr_pkg::OPFSR_LD_REQ, idx: 4'h0, we: 1'b0, data: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    // Request stands through the wait until acknowledged
    assign shadow_rd_req = (s_q.st == opfsr_pkg::OPFSR_LD_WAIT);
    assign shadow_addr   = opfsr_pkg::SHADOW_BASE + {12'h000, s_q.idx};
    assign load_we       = s_q.we;
    // Index has already stepped on unless the last byte was taken
    assign load_idx      = (s_q.we && s_q.st != opfsr_pkg::OPFSR_LD_DONE) ? s_q.idx - 4'h1
                                                                          : s_q.idx;
    assign load_data     = s_q.data;
    assign load_done     = (s_q.st == opfsr_pkg::OPFSR_LD_DONE) && !s_q.we;

endmodule : opfsr_shadow_loader

//--- core/opfsr_fault_combine.sv
////////////////////////////////////////////////////////////////////////////////
// Synchronises fault flags, gates them by the two masks, latches if asked
module opfsr_fault_combine (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  src_a_raw,
    input  wire logic [5:0]  src_b_raw,
    input  wire logic [7:0]  mask_a,
    input  wire logic [7:0]  mask_b,
    input  wire logic        sw_fault,
    input  wire logic        latch_mode,
    input  wire logic        latch_clr,
    output logic             fault_active
);

    typedef struct packed {
        logic [13:0] s1;
        logic [13:0] s2;
        logic [13:0] s3;
        logic [13:0] stable;
        logic        latch;
    } opfsr_fc_t;

    opfsr_fc_t  s_q;
    opfsr_fc_t  s_d;
    logic [7:0] flag_a;
    logic [7:0] flag_b;
    logic [7:0] gated_a;
    logic [7:0] gated_b;
    logic       any_fault;

    // Pin levels into fault sense; software bit sits in mask B bit 2
    assign flag_a = s_q.stable[13:6] ^ opfsr_pkg::SRC_A_INVERT;
    assign flag_b = {s_q.stable[5:1], sw_fault, s_q.stable[0], 1'b0}
                  ^ opfsr_pkg::SRC_B_INVERT;

    // One enable per source in each mask
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_gate
            assign gated_a[i] = mask_a[i] & flag_a[i];
            assign gated_b[i] = mask_b[i] & flag_b[i] & opfsr_pkg::MASK_B_USED[i];
        end
    endgenerate

    assign any_fault = (|gated_a) | (|gated_b);

    // A change counts only once the second and third stages agree
    always_comb begin
        s_d        = s_q;
        s_d.s1     = {src_a_raw, src_b_raw};
        s_d.s2     = s_q.s1;
        s_d.s3     = s_q.s2;
        s_d.stable = (s_q.s2 & ~(s_q.s2 ^ s_q.s3)) | (s_q.stable & (s_q.s2 ^ s_q.s3));
        // New fault wins over a clear in the same cycle
        if (latch_mode) begin
            s_d.latch = any_fault | (s_q.latch & ~latch_clr);
        end else begin
            s_d.latch = any_fault;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fault_active = s_q.latch;

endmodule : opfsr_fault_combine

//--- core/opfsr_regs.sv
////////////////////////////////////////////////////////////////////////////////
// Contract
// - After reset each register 13h..1Bh is loaded from shadow 8113h..811Bh in turn.
// - Polarity bit 7 sets the power-enable output polarity and bit 6 the fault output.
// - Polarity bit 5 sets the DC-good output polarity and bit 4 the AC-good output.
// - Polarity bit 3 sets the ORing gate drive; zero inverts it so low turns it on.
// - Bit 2 forces the share clamp when one and leaves it unclamped when zero.
// - Bit 1 is a software fault source, enabled by mask B bit 2 into the combined fault.
// - Writing bit 0 clears the fault latch when latching, which software does after service.
// - Register 14h holds the 8-bit divider common-mode offset trim code.
// - Register 15h holds the 8-bit sense amplifier dc offset trim code.
// - Register 18h holds the 8-bit false undervoltage clamp setting.
// - Register 19h holds the 8-bit load voltage trim setting.
// - Mask A enables eight fault sources, the ride-through timeout at bit 5.
// - Mask B enables supply-good, five monitors and the software bit at 2; bit 0 unused.
module opfsr_regs (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Register access from the management bus engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    // Shadow store read port
    output logic             shadow_rd_req,
    output logic [15:0]      shadow_addr,
    input  wire logic        shadow_rd_ack,
    input  wire logic [7:0]  shadow_rdata,
    output logic             config_ready,
    // Raw status from the supply logic (same clock)
    input  wire logic        power_enable_raw,
    input  wire logic        dc_good_raw,
    input  wire logic        ac_good_raw,
    input  wire logic        oring_on_raw,
    input  wire logic        fault_latch_mode,
    // Fault sources from analogue comparators (asynchronous)
    input  wire logic [7:0]  fault_src_a_raw,
    input  wire logic [5:0]  fault_src_b_raw,
    // Pin drives
    output logic             power_enable_output,
    output logic             fault_output,
    output logic             dc_good_output,
    output logic             ac_good_output,
    output logic             oring_gate_drive,
    output logic             share_clamp_force,
    output logic             alert_n,
    // Analogue settings
    output logic [7:0]       divider_offset_trim_code,
    output logic [7:0]       amp_offset_trim_code,
    output logic [7:0]       sense_gain_range_bits,
    output logic [7:0]       sense_mode_bits,
    output logic [7:0]       false_undervolt_clamp_code,
    output logic [7:0]       load_voltage_trim_code,
    output logic [7:0]       fault_route_mask_a_bits,
    output logic [7:0]       fault_route_mask_b_bits
);

    typedef struct packed {
        logic [opfsr_pkg::NUM_REGS-1:0][7:0] bank;
        logic [7:0]                          rdata;
        logic                                rvalid;
        logic                                clr;
        logic                                pwr_en;
        logic                                fault;
        logic                                dc;
        logic                                ac;
        logic                                oring;
        logic                                alert_n;
    } opfsr_regs_t;

    opfsr_regs_t s_q;
    opfsr_regs_t s_d;

    logic        load_we;
    logic [3:0]  load_idx;
    logic [7:0]  load_data;
    logic        load_done;
    logic        fault_active;
    logic        addr_hit;
    logic [3:0]  addr_idx;
    logic [7:0]  pol;

    ////////////////////////////////////////////////////////////////////////////
    // Power-up fill of the bank from the shadow store

    opfsr_shadow_loader u_loader (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .shadow_rd_req (shadow_rd_req),
        .shadow_addr   (shadow_addr),
        .shadow_rd_ack (shadow_rd_ack),
        .shadow_rdata  (shadow_rdata),
        .load_we       (load_we),
        .load_idx      (load_idx),
        .load_data     (load_data),
        .load_done     (load_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Offsets are contiguous, so the index is the offset minus the first one
    assign addr_hit = (reg_addr >= opfsr_pkg::OFS_POLARITY)
                   && (reg_addr <= opfsr_pkg::OFS_MASK_B);
    assign addr_idx = 4'(reg_addr - opfsr_pkg::OFS_POLARITY);
    assign pol      = s_q.bank[0];

    ////////////////////////////////////////////////////////////////////////////
    // Fault combination across both masks

    opfsr_fault_combine u_fault (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .src_a_raw    (fault_src_a_raw),
        .src_b_raw    (fault_src_b_raw),
        .mask_a       (s_q.bank[7]),
        .mask_b       (s_q.bank[8]),
        .sw_fault     (pol[opfsr_pkg::SW_FAULT_BIT]),
        .latch_mode   (fault_latch_mode),
        .latch_clr    (s_q.clr),
        .fault_active (fault_active)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the bank and the pin drives

    always_comb begin
        s_d        = s_q;
        s_d.clr    = 1'b0;
        s_d.rvalid = 1'b0;

        // Shadow load owns the bank until it finishes; bus writes before then are dropped
        if (load_we) begin
            s_d.bank[load_idx] = load_data;
        end else if (reg_wr && addr_hit && load_done) begin
            s_d.bank[addr_idx] = reg_wdata;
            if (addr_idx == 4'h0 && reg_wdata[opfsr_pkg::LATCH_CLR_BIT]) begin
                s_d.clr = 1'b1;
            end
        end

        // Reads answer one cycle later; unmapped offsets read zero
        if (reg_rd) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = opfsr_pkg::RDATA_RESET;
            if (addr_hit) begin
                s_d.rdata = s_q.bank[addr_idx];
                if (addr_idx == 4'h0) begin
                    s_d.rdata = s_q.bank[0] & opfsr_pkg::POL_READ_MASK;
                end
            end
        end

        // Polarity bit one passes the raw level, zero inverts it
        s_d.pwr_en = pol[opfsr_pkg::POL_PWR_EN_BIT] ? power_enable_raw
                                                    : ~power_enable_raw;
        s_d.fault = pol[opfsr_pkg::POL_FAULT_BIT] ? fault_active
                                                  : ~fault_active;
        s_d.dc    = pol[opfsr_pkg::POL_DC_BIT] ? dc_good_raw : ~dc_good_raw;
        s_d.ac    = pol[opfsr_pkg::POL_AC_BIT] ? ac_good_raw : ~ac_good_raw;
        s_d.oring = pol[opfsr_pkg::POL_ORING_BIT] ? oring_on_raw
                                                  : ~oring_on_raw;
        // Alert follows the combined fault before polarity, always active low
        s_d.alert_n = ~fault_active;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q         <= '0;
            s_q.bank    <= {opfsr_pkg::NUM_REGS{opfsr_pkg::REG_RESET}};
            s_q.alert_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from flops; config_ready is decoded from the loader state

    assign reg_rdata                  = s_q.rdata;
    assign reg_rvalid                 = s_q.rvalid;
    assign config_ready               = load_done;
    assign power_enable_output        = s_q.pwr_en;
    assign fault_output               = s_q.fault;
    assign dc_good_output             = s_q.dc;
    assign ac_good_output             = s_q.ac;
    assign oring_gate_drive           = s_q.oring;
    assign share_clamp_force          = pol[opfsr_pkg::SHARE_CLAMP_BIT];
    assign alert_n                    = s_q.alert_n;
    assign divider_offset_trim_code   = s_q.bank[1];
    assign amp_offset_trim_code       = s_q.bank[2];
    assign sense_gain_range_bits      = s_q.bank[3];
    assign sense_mode_bits            = s_q.bank[4];
    assign false_undervolt_clamp_code = s_q.bank[5];
    assign load_voltage_trim_code     = s_q.bank[6];
    assign fault_route_mask_a_bits    = s_q.bank[7];
    assign fault_route_mask_b_bits    = s_q.bank[8] & opfsr_pkg::MASK_B_USED;

endmodule : opfsr_regs

//--- verif/opfsr_regs_props.sv
////////////////////////////////////////////////////////////////////////////////
module opfsr_regs_props (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        shadow_rd_req,
    input wire logic [15:0] shadow_addr,
    input wire logic        shadow_rd_ack,
    input wire logic        config_ready,
    input wire logic        power_enable_raw,
    input wire logic        oring_on_raw,
    input wire logic        power_enable_output,
    input wire logic        oring_gate_drive,
    input wire logic        share_clamp_force,
    input wire logic [7:0]  divider_offset_trim_code,
    input wire logic [7:0]  fault_route_mask_b_bits
);
    // One domain, so clocking and reset are given once
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    chk_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h13 || reg_addr > 8'h1B)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_write_readback: assert property (reg_wr && config_ready && reg_addr == 8'h19
        ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == 8'h19 |=> reg_rdata == $past(reg_wdata, 3))
        else $error("load trim readback wrong");
    chk_trim_drive: assert property (reg_wr && config_ready && reg_addr == 8'h14
        |=> divider_offset_trim_code == $past(reg_wdata)) else $error("trim pins wrong");
    chk_mask_unused: assert property (reg_wr && config_ready && reg_addr == 8'h1B
        |=> fault_route_mask_b_bits == ($past(reg_wdata) & 8'hFE)) else $error("mask b wrong");
    chk_clamp_force: assert property (reg_wr && config_ready && reg_addr == 8'h13
        |=> share_clamp_force == |($past(reg_wdata) & 8'h04)) else $error("clamp wrong");
    // Polarity held steady for three edges: a raw change must reach the pin
    chk_pen_follows: assert property (config_ready && $past(config_ready, 2) && !reg_wr
        && !$past(reg_wr) && !$past(reg_wr, 2) && $changed(power_enable_raw)
        |=> $changed(power_enable_output)) else $error("enable pin stuck");
    chk_oring_follows: assert property ((config_ready && !reg_wr) [*3]
        ##0 $changed(oring_on_raw) |=> oring_gate_drive != $past(oring_gate_drive))
        else $error("gate drive stuck");
    chk_shadow_hold: assert property (shadow_rd_req && !shadow_rd_ack
        |=> shadow_rd_req && $stable(shadow_addr)) else $error("shadow request dropped");
    chk_shadow_range: assert property (shadow_rd_req
        |-> shadow_addr >= 16'h8113 && shadow_addr <= 16'h811B) else $error("shadow addr out");
    chk_ready_sticks: assert property (config_ready
        |=> config_ready && !shadow_rd_req) else $error("load restarted");
endmodule : opfsr_regs_props

bind opfsr_regs opfsr_regs_props u_props (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .reg_rvalid, .shadow_rd_req, .shadow_addr, .shadow_rd_ack,
    .config_ready, .power_enable_raw, .oring_on_raw, .power_enable_output, .oring_gate_drive,
    .share_clamp_force, .divider_offset_trim_code, .fault_route_mask_b_bits);

//--- verif/opfsr_shadow_model.sv
////////////////////////////////////////////////////////////////////////////////
module opfsr_shadow_model (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        slow,
    input wire logic        shadow_rd_req,
    input wire logic [15:0] shadow_addr,
    output logic            shadow_rd_ack,
    output logic [7:0]      shadow_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_q;

    // Answers after a random stall when slow, none before the first; data is scrambled when not acknowledged
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shadow_rd_ack <= 1'b0;
            shadow_rdata  <= 8'h5A;
            wait_q        <= 3'd0;
        end else if (shadow_rd_req && !shadow_rd_ack && wait_q == 3'd0) begin
            shadow_rd_ack <= 1'b1;
            shadow_rdata  <= 8'(shadow_addr[7:0] * 8'h1D) ^ 8'h5A;
            wait_q        <= slow ? 3'($urandom_range(5, 1)) : 3'd0;
        end else begin
            shadow_rd_ack <= 1'b0;
            shadow_rdata  <= ~shadow_rdata;
            if (shadow_rd_req && wait_q != 3'd0) begin
                wait_q <= wait_q - 3'd1;
            end
        end
    end
endmodule : opfsr_shadow_model

//--- verif/tb_output_polarity_fault_select_regs.sv
////////////////////////////////////////////////////////////////////////////////
module tb_output_polarity_fault_select_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        resetn, slow, reg_wr, reg_rd, reg_rvalid, shadow_rd_req, shadow_rd_ack;
    logic        config_ready, power_enable_raw, dc_good_raw, ac_good_raw, oring_on_raw;
    logic        fault_latch_mode, power_enable_output, fault_output, dc_good_output;
    logic        ac_good_output, oring_gate_drive, share_clamp_force, alert_n;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, shadow_rdata, fault_src_a_raw;
    logic [7:0]  divider_offset_trim_code, amp_offset_trim_code, sense_gain_range_bits;
    logic [7:0]  sense_mode_bits, false_undervolt_clamp_code, load_voltage_trim_code;
    logic [7:0]  fault_route_mask_a_bits, fault_route_mask_b_bits;
    logic [5:0]  fault_src_b_raw;
    logic [15:0] shadow_addr;
    int          err_total, checked;
    wire  [3:0]  pins = {power_enable_output, dc_good_output, ac_good_output, oring_gate_drive};
    wire  [63:0] trims = {fault_route_mask_b_bits, fault_route_mask_a_bits,
        load_voltage_trim_code, false_undervolt_clamp_code, sense_mode_bits,
        sense_gain_range_bits, amp_offset_trim_code, divider_offset_trim_code};

    opfsr_regs u_dut (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .reg_rvalid, .shadow_rd_req, .shadow_addr, .shadow_rd_ack, .shadow_rdata, .config_ready,
        .power_enable_raw, .dc_good_raw, .ac_good_raw, .oring_on_raw, .fault_latch_mode,
        .fault_src_a_raw, .fault_src_b_raw, .power_enable_output, .fault_output,
        .dc_good_output, .ac_good_output, .oring_gate_drive, .share_clamp_force, .alert_n,
        .divider_offset_trim_code, .amp_offset_trim_code, .sense_gain_range_bits,
        .sense_mode_bits, .false_undervolt_clamp_code, .load_voltage_trim_code,
        .fault_route_mask_a_bits, .fault_route_mask_b_bits);
    opfsr_shadow_model u_store (.sys_clk, .resetn, .slow, .shadow_rd_req, .shadow_addr,
        .shadow_rd_ack, .shadow_rdata);

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    function automatic logic [7:0] nv_expect(input int i);
        return 8'((8'h13 + 8'(i)) * 8'h1D) ^ 8'h5A;
    endfunction : nv_expect

    task automatic chk(input string what, input logic [7:0] exp, got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bus tasks end one idle cycle after the strobe drops, so a strobe never rises
    // in the same step that lowered it
    task automatic wr(input logic [7:0] a, d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        @(negedge sys_clk);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, exp);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk($sformatf("reg %h", a), exp, reg_rdata);
        @(negedge sys_clk);
    endtask : rd_chk

    // Masks, polarity and sources set; fault seen after the synchroniser settles
    task automatic fault_case(input logic [7:0] ma, mb, sa, input logic [5:0] sb,
                              input logic sw, f);
        logic       pol;
        logic [7:0] cfg;
        pol = 1'($urandom);
        cfg = (8'($urandom) & 8'hBC) | {1'b0, pol, 4'h0, sw, 1'b0};
        wr(8'h1A, ma);
        wr(8'h1B, mb);
        wr(8'h13, cfg);
        fault_src_a_raw = sa;
        fault_src_b_raw = sb;
        repeat (10) @(negedge sys_clk);
        chk("alert_n", {7'h00, ~f}, {7'h00, alert_n});
        chk("fault_output", {7'h00, pol ? f : ~f}, {7'h00, fault_output});
        fault_src_a_raw = 8'h13;
        fault_src_b_raw = 6'h20;
        repeat (10) @(negedge sys_clk);
    endtask : fault_case

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        #200us;
        err_total++;
        complete_run();
    end

    initial begin
        logic [7:0] d;
        logic [3:0] r;
        int         j;
        void'($urandom(12));
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {power_enable_raw, dc_good_raw, ac_good_raw, oring_on_raw, fault_latch_mode} = '0;
        fault_src_a_raw = 8'h13;
        fault_src_b_raw = 6'h20;
        // Two power-ups: slow store first, then a prompt one
        for (int p = 0; p < 2; p++) begin
            resetn = 1'b0;
            slow   = (p == 0);
            repeat (10) @(negedge sys_clk);
            resetn = 1'b1;
            for (int i = 0; i < 400 && !config_ready; i++) begin
                @(negedge sys_clk);
            end
            chk("config_ready", 8'h01, {7'h00, config_ready});
            for (int i = 0; i < 9; i++) begin
                rd_chk(8'h13 + 8'(i), i == 0 ? nv_expect(i) & 8'hFB : nv_expect(i));
            end
            chk("div trim pins", nv_expect(1), divider_offset_trim_code);
        end
        $display("test shadow load done");
        for (int a = 8'h14; a <= 8'h1B; a++) begin
            d = 8'($urandom);
            wr(8'(a), d);
            rd_chk(8'(a), d);
            chk("trims", d & {7'h7F, a != 8'h1B}, trims[(a - 8'h14) * 8 +: 8]);
        end
        wr(8'h1C, 8'hFF);
        rd_chk(8'h1C, 8'h00);
        rd_chk(8'h12, 8'h00);
        $display("test register access done");
        repeat (8) begin
            d = 8'($urandom) & 8'hFC;
            r = 4'($urandom);
            wr(8'h13, d);
            repeat (3) @(negedge sys_clk);
            {power_enable_raw, dc_good_raw, ac_good_raw, oring_on_raw} = r;
            repeat (2) @(negedge sys_clk);
            chk("polarity pins", {4'h0, r ^ ~{d[7], d[5:3]}}, {4'h0, pins});
            chk("share clamp", {7'h00, d[2]}, {7'h00, share_clamp_force});
            rd_chk(8'h13, d & 8'hFB);
        end
        $display("test polarity done");
        // Each source alone: masked off by all other bits, then enabled by its own
        for (int k = 0; k < 16; k++) begin
            j = k - 8;
            if (k < 8) begin
                fault_case(~(8'h01 << k), 8'h00, 8'h13 ^ (8'h01 << k), 6'h20, 1'b0, 1'b0);
                fault_case(8'h01 << k, 8'h00, 8'h13 ^ (8'h01 << k), 6'h20, 1'b0, 1'b1);
            end else if (j == 0) begin
                fault_case(8'h00, 8'h01, 8'h13, 6'h1F, 1'b1, 1'b0);
            end else begin
                r = (j == 1) ? 4'd0 : 4'(j - 2);
                d = {2'b00, (j == 2) ? 6'h20 : 6'h20 ^ (6'h01 << r)};
                fault_case(8'h00, ~(8'h01 << j) & 8'hFE, 8'h13, d[5:0], j == 2, 1'b0);
                fault_case(8'h00, 8'h01 << j, 8'h13, d[5:0], j == 2, 1'b1);
            end
        end
        $display("test fault routing done");
        fault_latch_mode = 1'b1;
        wr(8'h1A, 8'h80);
        wr(8'h1B, 8'h00);
        wr(8'h13, 8'h40);
        fault_src_a_raw = 8'h93;
        repeat (10) @(negedge sys_clk);
        fault_src_a_raw = 8'h13;
        repeat (10) @(negedge sys_clk);
        chk("latched alert_n", 8'h00, {7'h00, alert_n});
        wr(8'h13, 8'h41);
        repeat (10) @(negedge sys_clk);
        chk("cleared alert_n", 8'h01, {7'h00, alert_n});
        fault_latch_mode = 1'b0;
        $display("test fault latch done");
        complete_run();
    end
endmodule : tb_output_polarity_fault_select_regs
